// file: test/ext_trig_seq_assertions.sv
// Timing checks on the acquisition sequencer ports
// Assumes the bench shrinks the level-mode final busy count to ten cycles
`timescale 1ns/100ps
module ext_trig_seq_assertions (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_ext_trig,
   input wire logic o_single_strobe,
   input wire logic o_cont_strobe,
   input wire logic o_integrating,
   input wire logic o_busy,
   input wire logic o_acq_error
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   property p_busy_src;
      $rose(o_busy) |-> $past(i_ext_trig) && !$past(i_ext_trig, 2);
   endproperty
   a_busy_src: assert property (p_busy_src)
      else $error("busy no edge");
   property p_integ_busy;
      o_integrating |-> o_busy;
   endproperty
   a_integ_busy: assert property (p_integ_busy)
      else $error("idle integ");
   property p_busy1;
      $rose(o_integrating) |-> $past(o_busy, 6);
   endproperty
   a_busy1: assert property (p_busy1)
      else $error("busy1 short");
   property p_busy2;
      $fell(o_integrating) |-> o_busy[*8] ##[1:10] !o_busy;
   endproperty
   a_busy2: assert property (p_busy2)
      else $error("busy2 length");
   // Strobe is already low in the first cycle after integration ends
   property p_ss_end;
      $fell(o_integrating) |-> (!o_single_strobe)[*4];
   endproperty
   a_ss_end: assert property (p_ss_end)
      else $error("strobe at end");
   property p_cs_window;
      o_cont_strobe |-> o_integrating || $past(o_integrating);
   endproperty
   a_cs_window: assert property (p_cs_window)
      else $error("cs out");
   property p_err;
      $rose(o_acq_error) |-> !$past(i_ext_trig);
   endproperty
   a_err: assert property (p_err)
      else $error("error while high");
   property p_ss_busy;
      o_single_strobe |-> o_busy;
   endproperty
   a_ss_busy: assert property (p_ss_busy)
      else $error("strobe idle");
endmodule
bind ext_trigger_acq_sequencer ext_trig_seq_assertions u_chk (
   .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_ext_trig(i_ext_trig),
   .o_single_strobe(o_single_strobe), .o_cont_strobe(o_cont_strobe),
   .o_integrating(o_integrating), .o_busy(o_busy),
   .o_acq_error(o_acq_error));

// file: test/ext_trig_src.sv
// External trigger source model driving the sequencer trigger input
// Assumes the bench calls pulse() from a process synchronous to the clock
`timescale 1ns/100ps
module ext_trig_src (
   input wire logic i_sys_clk,
   output logic o_trig
);
   initial o_trig = 1'b0;
   // High for exactly hi sampled edges, changed only after a rising edge
   task automatic pulse(input int hi);
      @(posedge i_sys_clk);
      o_trig <= 1'b1;
      repeat (hi) @(posedge i_sys_clk);
      o_trig <= 1'b0;
   endtask
endmodule

// file: test/ext_trigger_acq_sequencer_tb.sv
// Register, trigger and strobe tests for the acquisition sequencer
// Assumes shortened busy counts; level mode carries the long cycles
`timescale 1ns/100ps
`include "ext_trig_regs.svh"
module ext_trigger_acq_sequencer_tb;
   logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [3:0] ws = 4'hf;
   logic brdy = 1'b0, rrdy = 1'b0;
   logic [31:0] wd = 32'h0, rdat;
   logic [1:0] br, rr;
   logic awr, wrd, bv, arr, rv, ss, cs, integ, busy, err, irq, trig;
   int miscompares = 0, checks = 0, rises = 0, n1, n2, n3, n4;
   always #2.5 clk = ~clk;
   always @(posedge cs) rises++;
   ext_trig_src src (.i_sys_clk(clk), .o_trig(trig));
   ext_trigger_acq_sequencer #(.EDGE_A_BUSY1_CYC(32'd20),
      .EDGE_A_BUSY2_CYC(32'd20), .EDGE_B_BUSY2_CYC(32'd30),
      .LVL_BUSY2_CYC(32'd10), .LVL_PULSE_MIN_CYC(32'd40)) dut (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_ext_trig(trig),
      .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
      .i_wstrb(ws), .i_wvalid(wv), .o_wready(wrd), .o_bresp(br),
      .o_bvalid(bv), .i_bready(brdy), .i_araddr(ara), .i_arvalid(arv),
      .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv),
      .i_rready(rrdy), .o_single_strobe(ss), .o_cont_strobe(cs),
      .o_integrating(integ), .o_busy(busy), .o_acq_error(err), .o_irq(irq));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return busy;
         1: return integ;
         2: return ss;
         3: return irq;
         default: return err;
      endcase
   endfunction
   task automatic wait_for(input int s, input logic v, output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (pick(s) !== v && c < 2000);
   endtask
   task automatic pk(input int s, input logic e);
      repeat (2) @(posedge clk);
      chk({31'h0, pick(s)}, {31'h0, e});
   endtask
   // Each channel is released at the edge its own ready is seen high
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      {awa, wd, awv, wv} <= {a, d, 2'b11};
      while (!(ad && dd)) begin
         @(posedge clk);
         ad = ad | awr;
         dd = dd | wrd;
         if (ad) awv <= 1'b0;
         if (dd) wv <= 1'b0;
      end
      brdy <= 1'b1;
      do @(posedge clk); while (!bv);
      brdy <= 1'b0;
      chk({30'h0, br}, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
      {ara, arv} <= {a, 1'b1};
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      rrdy <= 1'b1;
      do @(posedge clk); while (!rv);
      rrdy <= 1'b0;
      chk(rdat, e);
      chk({30'h0, rr}, {30'h0, er});
   endtask
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`REG_CTRL, `CTRL_RST, 2'b00);
      rd(`REG_INTEG_TIME, `INTEG_RST, 2'b00);
      rd(8'h2c, 32'h0, 2'b10);
      wr(`REG_ACQ_DELAY, 32'd400000);
      rd(`REG_ACQ_DELAY, 32'd335500, 2'b00);
      $display("test registers done");
      wr(`REG_IRQ_MASK, 32'h1);
      wr(`REG_CTRL, 32'h1);
      fork
         src.pulse(2);
         wait_for(3, 1'b1, n1);
      join
      chk(32'(n1 >= 5 && n1 <= 8), 32'h1);
      wr(`REG_IRQ_MASK, 32'h0);
      pk(3, 1'b0);
      rd(`REG_IRQ_STATUS, 32'h1, 2'b00);
      wr(`REG_CTRL, 32'h0);
      pk(0, 1'b0);
      wr(`REG_IRQ_MASK, 32'h1);
      pk(3, 1'b1);
      wr(`REG_IRQ_STATUS, 32'h1);
      pk(3, 1'b0);
      $display("test edge and interrupt done");
      wr(`REG_ACQ_DELAY, 32'h1);
      ws <= 4'h1;
      wr(`REG_SS_DELAY, 32'hffffff01);
      ws <= 4'hf;
      wr(`REG_SS_WIDTH, 32'h1);
      wr(`REG_CS_PERIOD, 32'h2);
      wr(`REG_CS_OFF, 32'h1);
      wr(`REG_CTRL, 32'h3);
      fork
         src.pulse(300);
         begin
            wait_for(2, 1'b1, n1);
            wait_for(2, 1'b0, n1);
         end
         begin
            wait_for(1, 1'b1, n2);
            wait_for(1, 1'b0, n3);
            wait_for(0, 1'b0, n4);
         end
      join
      chk(32'(n2 >= 404 && n2 <= 410), 32'h1);
      chk(32'(n3 >= 299 && n3 <= 301), 32'h1);
      chk(32'(n4 >= 9 && n4 <= 12), 32'h1);
      chk(32'(n1 >= 199 && n1 <= 201), 32'h1);
      chk(32'(rises > 0), 32'h1);
      rd(`REG_PULSE_WIDTH, 32'd300, 2'b00);
      chk({31'h0, err}, 32'h0);
      $display("test level done");
      fork
         src.pulse(20);
         wait_for(4, 1'b1, n1);
      join
      chk(32'(n1 >= 22 && n1 <= 24), 32'h1);
      wait_for(0, 1'b0, n1);
      rd(`REG_STATUS, 32'h4, 2'b00);
      $display("test short pulse done");
      report_and_stop();
   end
endmodule

// file: verilog/acq_strobe_gen.sv
// Single and continuous strobe generators for one acquisition cycle
// Assumes event and integration pulses come from the sequencer
`timescale 1ns/100ps
module acq_strobe_gen (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_event,
   input wire logic i_integ_start,
   input wire logic i_integ_end,
   input wire logic i_full_only,
   input wire logic [31:0] i_rem,
   input wire ext_trig_pkg::strobe_cfg_t i_cfg,
   output logic o_single_strobe,
   output logic o_cont_strobe
);
   logic ss_arm;
   logic [32:0] ss_cnt;
   logic cs_run;
   logic [31:0] pcnt;

   wire logic [32:0] ss_start = {1'b0, i_cfg.ss_delay};
   wire logic [32:0] ss_stop = ss_start + {1'b0, i_cfg.ss_width};
   // Delay runs from the trigger event, width sets the pulse
   wire logic next_ss_arm = i_event |
      (ss_arm & ~i_integ_end & (ss_cnt < ss_stop));
   wire logic [32:0] next_ss_cnt = i_event ? 33'h000000000 : ss_cnt + 33'h1;
   wire logic next_single = next_ss_arm & (next_ss_cnt >= ss_start) &
      (next_ss_cnt < ss_stop);

   wire logic cs_wrap = pcnt == i_cfg.cs_period - 32'h1;
   // Edge mode only starts a period that fits entirely
   wire logic cs_more = ~i_full_only | (i_rem > i_cfg.cs_period);
   wire logic next_cs_run = i_integ_start ? i_cfg.cs_on :
      (cs_run & ~i_integ_end & (~cs_wrap | cs_more));
   wire logic [31:0] next_pcnt = (i_integ_start | cs_wrap) ? 32'h00000000 :
      pcnt + 32'h1;
   // High for period minus off time, then low for the off time
   wire logic [31:0] cs_high = i_cfg.cs_period - i_cfg.cs_off;
   wire logic next_cont = next_cs_run & (next_pcnt < cs_high);

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ss_arm <= 1'b0;
         ss_cnt <= 33'h000000000;
         cs_run <= 1'b0;
         pcnt <= 32'h00000000;
         o_single_strobe <= 1'b0;
         o_cont_strobe <= 1'b0;
      end else begin
         ss_arm <= next_ss_arm;
         ss_cnt <= next_ss_cnt;
         cs_run <= next_cs_run;
         pcnt <= next_pcnt;
         o_single_strobe <= next_single;
         o_cont_strobe <= next_cont;
      end
   end
endmodule

// file: verilog/axil_reg_port.sv
// AXI4-Lite slave front end: one write and one read in flight
// Assumes read data from the register file is combinational on o_rd_addr
`timescale 1ns/100ps
module axil_reg_port (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output ext_trig_pkg::reg_wr_t o_wr,
   output logic [7:0] o_rd_addr,
   input wire logic [31:0] i_rd_data
);
   logic aw_full;
   logic w_full;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   wire logic aw_take = i_awvalid & o_awready;
   wire logic w_take = i_wvalid & o_wready;
   wire logic issue = aw_full & w_full & ~o_bvalid;
   wire logic ar_take = i_arvalid & o_arready;
   wire logic aw_ok = ext_trig_pkg::reg_mapped(aw_addr);
   wire logic ar_ok = ext_trig_pkg::reg_mapped(i_araddr);

   assign o_rd_addr = i_araddr;

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= 2'h0;
         o_wr <= '0;
      end else begin
         o_wr.valid <= issue;
         if (aw_take) begin
            aw_full <= 1'b1;
            aw_addr <= i_awaddr;
            o_awready <= 1'b0;
         end
         if (w_take) begin
            w_full <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
            o_wready <= 1'b0;
         end
         if (issue) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            o_wr.addr <= aw_addr;
            o_wr.data <= w_data;
            o_wr.strb <= aw_ok ? w_strb : 4'h0;
            o_bvalid <= 1'b1;
            o_bresp <= aw_ok ? 2'h0 : 2'h2;
         end
         if (o_bvalid & i_bready) begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= 2'h0;
      end else if (ar_take) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b1;
         o_rdata <= ar_ok ? i_rd_data : 32'h00000000;
         o_rresp <= ar_ok ? 2'h0 : 2'h2;
      end else if (o_rvalid & i_rready) begin
         o_rvalid <= 1'b0;
         o_arready <= 1'b1;
      end
   end
endmodule

// file: verilog/ext_trig_pkg.sv
// Types shared by the acquisition sequencer and its helpers
// Offsets and counts live in ext_trig_regs.svh
package ext_trig_pkg;
`include "ext_trig_regs.svh"

   typedef enum logic {TRIG_EDGE, TRIG_LEVEL} trig_mode_t;

   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } reg_wr_t;

   typedef struct packed {
      logic [31:0] ss_delay;
      logic [31:0] ss_width;
      logic [31:0] cs_period;
      logic [31:0] cs_off;
      logic cs_on;
   } strobe_cfg_t;

   function automatic logic reg_mapped(input logic [7:0] a);
      return a inside {`REG_CTRL, `REG_ACQ_DELAY, `REG_INTEG_TIME,
         `REG_SS_DELAY, `REG_SS_WIDTH, `REG_CS_PERIOD, `REG_CS_OFF,
         `REG_STATUS, `REG_IRQ_STATUS, `REG_IRQ_MASK, `REG_PULSE_WIDTH};
   endfunction
endpackage

// file: verilog/ext_trig_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 200 MHz system clock and an 8-bit AXI4-Lite byte address
`ifndef EXT_TRIG_REGS_SVH
`define EXT_TRIG_REGS_SVH

`define CLK_PERIOD_NS 5
`define CYC_PER_US (1000 / `CLK_PERIOD_NS)

`define ETRG_DLY_MIN_NS 20
`define ETRG_DLY_MAX_NS 30
`define ETRG_DLY_CYC ((`ETRG_DLY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EDGE_MIN_HIGH_NS 10

`define ACQ_DLY_MAX_US 335500
`define STROBE_MAX_US 10000000

`define LVL_BUSY1_US 1
`define LVL_BUSY1_CYC (`LVL_BUSY1_US * `CYC_PER_US)
`define LVL_BUSY2_US 218
`define LVL_PULSE_MIN_US 220
`define LVL_PULSE_MAX_US 6000000

`define EDGE_A_BUSY1_US 3706
`define EDGE_A_BUSY2_US 3706
`define EDGE_A_INTEG_MIN_US 3800
`define EDGE_A_INTEG_MAX_US 10000000
`define EDGE_B_BUSY1_NS 15
`define EDGE_B_BUSY1_CYC ((`EDGE_B_BUSY1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EDGE_B_BUSY2_US 4977
`define EDGE_B_INTEG_MIN_US 7200
`define EDGE_B_INTEG_MAX_US 5000000

`define REG_CTRL 8'h00
`define REG_ACQ_DELAY 8'h04
`define REG_INTEG_TIME 8'h08
`define REG_SS_DELAY 8'h0c
`define REG_SS_WIDTH 8'h10
`define REG_CS_PERIOD 8'h14
`define REG_CS_OFF 8'h18
`define REG_STATUS 8'h1c
`define REG_IRQ_STATUS 8'h20
`define REG_IRQ_MASK 8'h24
`define REG_PULSE_WIDTH 8'h28

`define CTRL_EN_BIT 0
`define CTRL_LEVEL_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_INTEG_BIT 1
`define STAT_ERR_BIT 2
`define IRQ_TRIG_BIT 0
`define IRQ_INTEG_BIT 1
`define IRQ_DONE_BIT 2
`define IRQ_WIDTH_ERR_BIT 3

`define CTRL_RST 32'h00000000
`define INTEG_RST 32'h00000ed8
`define ZERO_RST 32'h00000000

`endif

// file: verilog/ext_trigger_acq_sequencer.sv
// Acquisition-cycle sequencer for edge and level external trigger modes
// Assumes i_ext_trig is synchronous to i_sys_clk; AXI4-Lite register access
`timescale 1ns/100ps
`include "ext_trig_regs.svh"
module ext_trigger_acq_sequencer #(
   parameter logic EDGE_VARIANT_B = 1'b0,
   parameter logic [31:0] EDGE_A_BUSY1_CYC =
      32'(`EDGE_A_BUSY1_US * `CYC_PER_US),
   parameter logic [31:0] EDGE_A_BUSY2_CYC =
      32'(`EDGE_A_BUSY2_US * `CYC_PER_US),
   parameter logic [31:0] EDGE_B_BUSY2_CYC =
      32'(`EDGE_B_BUSY2_US * `CYC_PER_US),
   parameter logic [31:0] LVL_BUSY2_CYC = 32'(`LVL_BUSY2_US * `CYC_PER_US),
   parameter logic [31:0] LVL_PULSE_MIN_CYC =
      32'(`LVL_PULSE_MIN_US * `CYC_PER_US)
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_ext_trig,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic o_single_strobe,
   output logic o_cont_strobe,
   output logic o_integrating,
   output logic o_busy,
   output logic o_acq_error,
   output logic o_irq
);
   typedef enum logic [2:0] {
      S_IDLE, S_TRIG_DLY, S_BUSY1, S_ACQ_DLY, S_INTEG, S_BUSY2
   } seq_state_t;

   function automatic logic [31:0] us_to_cyc(input logic [31:0] us);
      return 32'(us * `CYC_PER_US);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (data & m);
   endfunction

   function automatic logic [31:0] clamp(input logic [31:0] v,
      input logic [31:0] lo, input logic [31:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   ext_trig_pkg::reg_wr_t wr;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;

   logic [31:0] ctrl;
   logic [31:0] acq_us;
   logic [31:0] integ_us;
   logic [31:0] ssd_us;
   logic [31:0] ssw_us;
   logic [31:0] csp_us;
   logic [31:0] cso_us;
   logic [3:0] irq_st;
   logic [3:0] irq_mask;

   seq_state_t state;
   seq_state_t next_state;
   logic [31:0] cnt;
   logic [31:0] cur_len;
   ext_trig_pkg::trig_mode_t run_mode;
   logic [31:0] acq_len;
   logic [31:0] integ_len;
   ext_trig_pkg::strobe_cfg_t cfg;
   logic trig_q;
   logic pulse_on;
   logic [31:0] wcnt;

   axil_reg_port u_axil (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid),
      .o_awready(o_awready),
      .i_wdata(i_wdata),
      .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid),
      .o_wready(o_wready),
      .o_bresp(o_bresp),
      .o_bvalid(o_bvalid),
      .i_bready(i_bready),
      .i_araddr(i_araddr),
      .i_arvalid(i_arvalid),
      .o_arready(o_arready),
      .o_rdata(o_rdata),
      .o_rresp(o_rresp),
      .o_rvalid(o_rvalid),
      .i_rready(i_rready),
      .o_wr(wr),
      .o_rd_addr(rd_addr),
      .i_rd_data(rd_data)
   );

   // Register write decode
   wire logic wr_ctrl = wr.valid && wr.addr == `REG_CTRL;
   wire logic wr_acq = wr.valid && wr.addr == `REG_ACQ_DELAY;
   wire logic wr_integ = wr.valid && wr.addr == `REG_INTEG_TIME;
   wire logic wr_ssd = wr.valid && wr.addr == `REG_SS_DELAY;
   wire logic wr_ssw = wr.valid && wr.addr == `REG_SS_WIDTH;
   wire logic wr_csp = wr.valid && wr.addr == `REG_CS_PERIOD;
   wire logic wr_cso = wr.valid && wr.addr == `REG_CS_OFF;
   wire logic wr_ist = wr.valid && wr.addr == `REG_IRQ_STATUS;
   wire logic wr_imask = wr.valid && wr.addr == `REG_IRQ_MASK;

   wire logic [31:0] integ_min = EDGE_VARIANT_B ?
      32'(`EDGE_B_INTEG_MIN_US) : 32'(`EDGE_A_INTEG_MIN_US);
   wire logic [31:0] integ_max = EDGE_VARIANT_B ?
      32'(`EDGE_B_INTEG_MAX_US) : 32'(`EDGE_A_INTEG_MAX_US);
   wire logic [31:0] strobe_max = 32'(`STROBE_MAX_US);
   // Clamping keeps every microsecond value inside a 32-bit cycle count
   wire logic [31:0] new_acq = clamp(merge(acq_us, wr.data, wr.strb),
      32'h00000000, 32'(`ACQ_DLY_MAX_US));
   wire logic [31:0] new_integ = clamp(merge(integ_us, wr.data, wr.strb),
      integ_min, integ_max);
   wire logic [31:0] new_ssd = clamp(merge(ssd_us, wr.data, wr.strb),
      32'h00000000, strobe_max);
   wire logic [31:0] new_ssw = clamp(merge(ssw_us, wr.data, wr.strb),
      32'h00000000, strobe_max);
   wire logic [31:0] new_csp = clamp(merge(csp_us, wr.data, wr.strb),
      32'h00000000, strobe_max);
   wire logic [31:0] new_cso = clamp(merge(cso_us, wr.data, wr.strb),
      32'h00000000, csp_us);
   wire logic [31:0] ist_clr = merge(32'h00000000, wr.data, wr.strb);

   wire logic enable = ctrl[`CTRL_EN_BIT];
   wire ext_trig_pkg::trig_mode_t mode = ctrl[`CTRL_LEVEL_BIT] ?
      ext_trig_pkg::TRIG_LEVEL : ext_trig_pkg::TRIG_EDGE;
   wire logic lvl_run = run_mode == ext_trig_pkg::TRIG_LEVEL;

   // Edges arriving mid-cycle are ignored; only an idle sequencer starts
   wire logic rise = i_ext_trig & ~trig_q;
   wire logic start = enable && state == S_IDLE && rise;

   wire logic [31:0] busy1_len = lvl_run ? 32'(`LVL_BUSY1_CYC) :
      (EDGE_VARIANT_B ? 32'(`EDGE_B_BUSY1_CYC) : EDGE_A_BUSY1_CYC);
   wire logic [31:0] busy2_len = lvl_run ? LVL_BUSY2_CYC :
      (EDGE_VARIANT_B ? EDGE_B_BUSY2_CYC : EDGE_A_BUSY2_CYC);

   assign cur_len = (state == S_TRIG_DLY) ? 32'(`ETRG_DLY_CYC) :
      (state == S_BUSY1) ? busy1_len :
      (state == S_ACQ_DLY) ? acq_len :
      (state == S_INTEG) ? integ_len : busy2_len;
   wire logic done = cnt + 32'h1 >= cur_len;
   // Level mode waits for the pulse to fall, then matches its length
   wire logic integ_done = lvl_run ?
      (~pulse_on && cnt + 32'h1 >= wcnt) : done;

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE: if (start) next_state = S_TRIG_DLY;
         S_TRIG_DLY: if (done) next_state = S_BUSY1;
         S_BUSY1: if (done) begin
            next_state = (acq_len != 32'h00000000) ? S_ACQ_DLY : S_INTEG;
         end
         S_ACQ_DLY: if (done) next_state = S_INTEG;
         S_INTEG: if (integ_done) next_state = S_BUSY2;
         S_BUSY2: if (done) next_state = S_IDLE;
      endcase
      if (!enable) next_state = S_IDLE;
   end

   wire logic [31:0] next_cnt = (next_state != state) ? 32'h00000000 :
      cnt + 32'h1;
   wire logic ev_trig = state == S_TRIG_DLY && next_state == S_BUSY1;
   wire logic integ_start = state != S_INTEG && next_state == S_INTEG;
   wire logic integ_end = state == S_INTEG && next_state != S_INTEG;
   wire logic cycle_done = state == S_BUSY2 && next_state == S_IDLE;
   wire logic [31:0] rem = integ_len - cnt;

   wire logic pulse_fall = pulse_on & ~i_ext_trig;
   wire logic width_err = pulse_fall && wcnt < LVL_PULSE_MIN_CYC;

   // Program values are snapshotted at the trigger so rewrites mid-cycle
   // cannot tear a running acquisition
   wire logic [31:0] csp_cyc = us_to_cyc(csp_us);
   wire logic [31:0] integ_cyc = us_to_cyc(integ_us);
   wire logic cs_ok = csp_us != 32'h00000000 &&
      (mode == ext_trig_pkg::TRIG_LEVEL || csp_cyc < integ_cyc);
   wire ext_trig_pkg::strobe_cfg_t next_cfg = '{
      ss_delay: us_to_cyc(ssd_us),
      ss_width: us_to_cyc(ssw_us),
      cs_period: csp_cyc,
      cs_off: us_to_cyc(cso_us),
      cs_on: cs_ok
   };

   wire logic [3:0] irq_set;
   assign irq_set[`IRQ_TRIG_BIT] = ev_trig;
   assign irq_set[`IRQ_INTEG_BIT] = integ_end;
   assign irq_set[`IRQ_DONE_BIT] = cycle_done;
   assign irq_set[`IRQ_WIDTH_ERR_BIT] = width_err;
   // A set in the same cycle as its clear survives
   wire logic [3:0] next_irq_st = (irq_st & ~(wr_ist ? ist_clr[3:0] : 4'h0))
      | irq_set;

   wire logic [31:0] status = {29'h00000000, o_acq_error, o_integrating,
      o_busy};
   assign rd_data = (rd_addr == `REG_CTRL) ? ctrl :
      (rd_addr == `REG_ACQ_DELAY) ? acq_us :
      (rd_addr == `REG_INTEG_TIME) ? integ_us :
      (rd_addr == `REG_SS_DELAY) ? ssd_us :
      (rd_addr == `REG_SS_WIDTH) ? ssw_us :
      (rd_addr == `REG_CS_PERIOD) ? csp_us :
      (rd_addr == `REG_CS_OFF) ? cso_us :
      (rd_addr == `REG_STATUS) ? status :
      (rd_addr == `REG_IRQ_STATUS) ? {28'h0000000, irq_st} :
      (rd_addr == `REG_IRQ_MASK) ? {28'h0000000, irq_mask} :
      (rd_addr == `REG_PULSE_WIDTH) ? wcnt : 32'h00000000;

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl <= `CTRL_RST;
         acq_us <= `ZERO_RST;
         integ_us <= `INTEG_RST;
         ssd_us <= `ZERO_RST;
         ssw_us <= `ZERO_RST;
         csp_us <= `ZERO_RST;
         cso_us <= `ZERO_RST;
         irq_mask <= 4'h0;
      end else begin
         if (wr_ctrl) ctrl <= merge(ctrl, wr.data, wr.strb) & 32'h00000003;
         if (wr_acq) acq_us <= new_acq;
         if (wr_integ) integ_us <= new_integ;
         if (wr_ssd) ssd_us <= new_ssd;
         if (wr_ssw) ssw_us <= new_ssw;
         if (wr_csp) csp_us <= new_csp;
         if (wr_cso) cso_us <= new_cso;
         if (wr_imask) irq_mask <= ist_clr[3:0];
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= S_IDLE;
         cnt <= 32'h00000000;
         trig_q <= 1'b0;
         o_busy <= 1'b0;
         o_integrating <= 1'b0;
         irq_st <= 4'h0;
         o_irq <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         trig_q <= i_ext_trig;
         o_busy <= next_state != S_IDLE;
         o_integrating <= next_state == S_INTEG;
         irq_st <= next_irq_st;
         o_irq <= |(next_irq_st & irq_mask);
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         run_mode <= ext_trig_pkg::TRIG_EDGE;
         acq_len <= 32'h00000000;
         integ_len <= 32'h00000000;
         cfg <= '0;
      end else if (start) begin
         run_mode <= mode;
         acq_len <= us_to_cyc(acq_us);
         integ_len <= integ_cyc;
         cfg <= next_cfg;
      end
   end

   // Pulse width is measured from the rising edge; the flag marks the
   // spectrum of this cycle as zeroed until the next trigger
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pulse_on <= 1'b0;
         wcnt <= 32'h00000000;
         o_acq_error <= 1'b0;
      end else begin
         if (start && mode == ext_trig_pkg::TRIG_LEVEL) begin
            pulse_on <= 1'b1;
            wcnt <= 32'h00000001;
         end else if (pulse_fall || !enable) begin
            pulse_on <= 1'b0;
         end else if (pulse_on && wcnt != 32'hffffffff) begin
            wcnt <= wcnt + 32'h1;
         end
         if (start) o_acq_error <= 1'b0;
         else if (width_err) o_acq_error <= 1'b1;
      end
   end

   acq_strobe_gen u_strobe (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_event(ev_trig),
      .i_integ_start(integ_start),
      .i_integ_end(integ_end),
      .i_full_only(~lvl_run),
      .i_rem(rem),
      .i_cfg(cfg),
      .o_single_strobe(o_single_strobe),
      .o_cont_strobe(o_cont_strobe)
   );
endmodule
